//--- rtl/decoder_regs.svh
`ifndef DECODER_REGS_SVH
`define DECODER_REGS_SVH

// Field positions inside a 24-bit instruction word
`define WORD_W        24
`define OPC_HI        23
`define OPC_LO        16
`define OPC_W         8

// Opcodes with a fixed meaning
`define OP_NOP        8'h00
`define OP_CALL_LONG  8'h02
`define OP_GOTO_LONG  8'h04
`define OP_DO_LOOP    8'h08
`define OP_IND_JUMP   8'h01
`define OP_RETURN     8'h06
`define OP_RET_INT    8'h07
`define OP_REL_BRANCH 8'h37
`define OP_TBL_READ   8'hBA
`define OP_TBL_WRITE  8'hBB
`define OP_MOV_DOUBLE 8'hBE
`define OP_MOV_LIT_F  8'hB3

// Opcode ranges by upper nibble
`define NIB_CTRL      4'h0
`define NIB_LIT       4'h2
`define NIB_COND      4'h3
`define NIB_BIT       4'hA
`define NIB_MISC      4'hB
`define NIB_DSP       4'hC
`define NIB_DSP2      4'hF

// Skip instructions occupy the bit group entries with these opcode bits 3:2
`define SKIP_SEL      2'b01

// Cycle counts
`define CYC_ONE       2'd1
`define CYC_TWO       2'd2
`define CYC_THREE     2'd3

`endif

//--- rtl/decoder_pkg.sv
package decoder_pkg;

    typedef enum logic [1:0] {
        ST_FIRST  = 2'b00,
        ST_SECOND = 2'b01,
        ST_STALL  = 2'b11
    } state_t;

    typedef enum logic [2:0] {
        CAT_WORD_BYTE = 3'h0,
        CAT_BIT       = 3'h1,
        CAT_LITERAL   = 3'h2,
        CAT_DSP       = 3'h3,
        CAT_CONTROL   = 3'h4
    } category_t;

    typedef struct packed {
        logic [7:0]  opcode;
        category_t   category;
        logic        two_word;
        logic [1:0]  cycles;
        logic [3:0]  base_source_reg;
        logic [3:0]  second_source_reg;
        logic [1:0]  src_mode;
        logic [3:0]  dest_reg;
        logic [1:0]  dest_mode;
        logic        dest_present;
        logic [12:0] file_addr;
        logic        to_file;
        logic [3:0]  bit_sel;
        logic        bit_indirect;
        logic [15:0] literal;
        logic        acc_sel;
        logic [2:0]  mult_pair;
        logic [3:0]  x_prefetch;
        logic [3:0]  y_prefetch;
        logic [1:0]  x_dest;
        logic [1:0]  y_dest;
        logic        awb_valid;
        logic        awb_indirect;
        logic        dsp_is_dest;
        logic        shift_by_reg;
        logic [3:0]  shift_amount_reg;
        logic [5:0]  shift_literal;
        logic [22:0] prog_addr;
        logic [1:0]  table_mode;
    } dec_t;

    typedef struct packed {
        state_t      st;
        logic [23:0] first_word;
        logic [1:0]  cnt;
        logic        issue;
        dec_t        dec;
    } core_t;

endpackage

//--- rtl/instr_decoder.sv
// How it works
// RULE1: 24-bit word, 8-bit opcode selects type
// RULE2: Exactly three instructions span two words
// RULE3: Two-word instruction decoded from 48 bits
// RULE4: Lone second word (top byte zero) is NOP
// RULE5: One cycle; two if taken/PC changed
// RULE6: Branch, indirect, table, returns take 2-3
// RULE7: Taken skip: 2 cycles, 3 over two-word
// RULE8: Double moves and two-word take two
// RULE9: Five categories of instruction
// RULE10: Word ops: base, second source, destination
// RULE11: File ops: address, file or default_work_reg
// RULE12: Bit ops: target, literal or indirect bit
// RULE13: Literal move: literal plus register target
// RULE14: Literal arithmetic: dest only when different
// RULE15: MAC: accumulator, multiplicands, prefetch, writeback
// RULE16: Other DSP: accumulator, operand, shift amount
// RULE17: Control: program address, table mode
// RULE18: Writeback is W13 direct or post-increment
// RULE19: Cycle count issued; extra slots are NOPs
`timescale 1ns/1ps
`include "decoder_regs.svh"

module instr_decoder (
    input  wire logic                   clk_sys,
    input  wire logic                   sys_rst,
    input  wire logic                   fetch_valid,
    input  wire logic [23:0]            fetch_word,
    input  wire logic [23:0]            next_word,
    input  wire logic                   cond_true,
    output logic                        fetch_ready,
    output logic                        issue_valid,
    output logic                        nop_slot,
    output logic [1:0]                  cycle_count,
    output decoder_pkg::category_t      category,
    output logic [7:0]                  opcode,
    output logic                        two_word,
    output logic [3:0]                  base_source_reg,
    output logic [3:0]                  second_source_reg,
    output logic [1:0]                  src_mode,
    output logic [3:0]                  dest_reg,
    output logic [1:0]                  dest_mode,
    output logic                        dest_present,
    output logic [12:0]                 file_addr,
    output logic                        to_file,
    output logic [3:0]                  bit_sel,
    output logic                        bit_indirect,
    output logic [15:0]                 literal,
    output logic                        acc_sel,
    output logic [2:0]                  mult_pair,
    output logic [3:0]                  x_prefetch,
    output logic [3:0]                  y_prefetch,
    output logic [1:0]                  x_dest,
    output logic [1:0]                  y_dest,
    output logic                        awb_valid,
    output logic                        awb_indirect,
    output logic                        dsp_is_dest,
    output logic                        shift_by_reg,
    output logic [3:0]                  shift_amount_reg,
    output logic [5:0]                  shift_literal,
    output logic [22:0]                 prog_addr,
    output logic [1:0]                  table_mode
);

    decoder_pkg::core_t core_reg;
    decoder_pkg::core_t core_next;
    decoder_pkg::dec_t  dec_now;

    function automatic logic is_two_word(input logic [7:0] op);
        is_two_word = (op == `OP_CALL_LONG) || (op == `OP_GOTO_LONG)
                      || (op == `OP_DO_LOOP); // see RULE2
    endfunction

    function automatic decoder_pkg::dec_t decode(
        input logic [23:0] w1,
        input logic [23:0] w2,
        input logic        cond,
        input logic [23:0] nxt
    );
        decoder_pkg::dec_t d;
        logic [7:0] op;
        logic [3:0] nib;
        d = '0;
        op = w1[`OPC_HI:`OPC_LO]; // see RULE1
        nib = op[7:4];
        d.opcode = op;
        d.two_word = is_two_word(op);
        // Category from the opcode
        case (nib) // see RULE9
            `NIB_CTRL, `NIB_COND: begin
                d.category = decoder_pkg::CAT_CONTROL;
            end
            `NIB_LIT: begin
                d.category = decoder_pkg::CAT_LITERAL;
            end
            `NIB_BIT: begin
                d.category = decoder_pkg::CAT_BIT;
            end
            `NIB_MISC: begin
                if (op[3:2] == 2'b00) begin
                    d.category = decoder_pkg::CAT_LITERAL;
                end else if (op == `OP_TBL_READ || op == `OP_TBL_WRITE) begin
                    d.category = decoder_pkg::CAT_CONTROL;
                end else begin
                    d.category = decoder_pkg::CAT_WORD_BYTE;
                end
            end
            `NIB_DSP, `NIB_DSP2: begin
                d.category = decoder_pkg::CAT_DSP;
            end
            default: begin
                d.category = decoder_pkg::CAT_WORD_BYTE;
            end
        endcase
        // Operand fields per category
        case (d.category)
            decoder_pkg::CAT_WORD_BYTE: begin
                if (nib == `NIB_MISC && op[3:2] == 2'b01) begin
                    d.file_addr = w1[12:0]; // see RULE11
                    d.to_file = w1[13];
                    d.dest_reg = 4'h0;
                end else begin
                    d.base_source_reg = w1[15:12]; // see RULE10
                    d.dest_mode = w1[11:10];
                    d.dest_reg = w1[9:6];
                    d.src_mode = w1[5:4];
                    d.second_source_reg = w1[3:0];
                    d.dest_present = 1'b1;
                end
            end
            decoder_pkg::CAT_BIT: begin
                d.bit_indirect = op[0]; // see RULE12
                d.bit_sel = w1[15:12];
                d.base_source_reg = w1[15:12];
                if (op[3]) begin
                    d.file_addr = {1'b0, w1[11:0]};
                    d.to_file = 1'b1;
                end else begin
                    d.src_mode = w1[5:4];
                    d.second_source_reg = w1[3:0];
                end
            end
            decoder_pkg::CAT_LITERAL: begin
                if (nib == `NIB_LIT) begin
                    d.literal = {op[3:0], w1[15:4]}; // see RULE13
                    d.base_source_reg = w1[3:0];
                end else if (op == `OP_MOV_LIT_F) begin
                    d.literal = {8'h00, w1[7:0]}; // see RULE13
                    d.file_addr = {5'h00, w1[15:8]};
                    d.to_file = 1'b1;
                end else begin
                    d.base_source_reg = w1[15:12]; // see RULE14
                    d.dest_present = op[0];
                    if (op[0]) begin
                        d.dest_mode = w1[11:10];
                        d.dest_reg = w1[9:6];
                        d.literal = {10'h000, w1[5:0]};
                    end else begin
                        d.dest_reg = w1[15:12];
                        d.literal = {4'h0, w1[11:0]};
                    end
                end
            end
            decoder_pkg::CAT_DSP: begin
                d.acc_sel = w1[15]; // see RULE15
                if (nib == `NIB_DSP && !op[3]) begin
                    d.mult_pair = w1[14:12];
                    d.x_prefetch = w1[11:8];
                    d.y_prefetch = w1[7:4];
                    d.x_dest = w1[3:2];
                    d.y_dest = w1[1:0];
                    d.awb_valid = op[0];
                    d.awb_indirect = op[1]; // see RULE18
                end else begin
                    d.dsp_is_dest = op[0]; // see RULE16
                    d.src_mode = w1[5:4];
                    d.second_source_reg = w1[3:0];
                    d.shift_by_reg = op[1];
                    d.shift_amount_reg = w1[9:6];
                    d.shift_literal = w1[11:6];
                end
            end
            default: begin
                d.literal = w1[15:0]; // see RULE17
                d.prog_addr = {w2[6:0], w1[15:1], 1'b0}; // see RULE3
                d.table_mode = {op[0], w1[14]};
                d.base_source_reg = w1[3:0];
            end
        endcase
        // Instruction cycles
        d.cycles = `CYC_ONE; // see RULE5
        if (d.two_word || op == `OP_MOV_DOUBLE) begin
            d.cycles = `CYC_TWO; // see RULE8
        end else if (op == `OP_RETURN || op == `OP_RET_INT) begin
            d.cycles = `CYC_THREE; // see RULE6
        end else if (op == `OP_REL_BRANCH || op == `OP_IND_JUMP
                     || op == `OP_TBL_READ || op == `OP_TBL_WRITE) begin
            d.cycles = `CYC_TWO; // see RULE6
        end else if (nib == `NIB_COND) begin
            d.cycles = cond ? `CYC_TWO : `CYC_ONE; // see RULE5
        end else if (nib == `NIB_BIT && op[3:2] == `SKIP_SEL && cond) begin
            d.cycles = is_two_word(nxt[`OPC_HI:`OPC_LO]) ? `CYC_THREE
                                                         : `CYC_TWO; // see RULE7
        end
        decode = d;
    endfunction

    // Lone second words carry a zero opcode and fall to the NOP row
    always_comb begin
        dec_now = decode(core_reg.first_word, fetch_word, cond_true, next_word); // see RULE4
        if (core_reg.st == decoder_pkg::ST_FIRST) begin
            dec_now = decode(fetch_word, 24'h000000, cond_true, next_word);
        end
    end

    always_comb begin
        core_next = core_reg;
        core_next.issue = 1'b0;
        case (core_reg.st)
            decoder_pkg::ST_FIRST: begin
                if (fetch_valid) begin
                    if (is_two_word(fetch_word[`OPC_HI:`OPC_LO])) begin
                        core_next.first_word = fetch_word; // see RULE3
                        core_next.st = decoder_pkg::ST_SECOND;
                    end else begin
                        core_next.dec = dec_now;
                        core_next.issue = 1'b1;
                        core_next.cnt = dec_now.cycles - `CYC_ONE;
                        if (dec_now.cycles != `CYC_ONE) begin
                            core_next.st = decoder_pkg::ST_STALL; // see RULE19
                        end
                    end
                end
            end
            decoder_pkg::ST_SECOND: begin
                if (fetch_valid) begin
                    core_next.dec = dec_now; // see RULE3
                    core_next.issue = 1'b1;
                    core_next.cnt = dec_now.cycles - `CYC_ONE;
                    core_next.st = decoder_pkg::ST_STALL; // see RULE8
                end
            end
            decoder_pkg::ST_STALL: begin
                core_next.cnt = core_reg.cnt - `CYC_ONE; // see RULE19
                if (core_reg.cnt == `CYC_ONE) begin
                    core_next.st = decoder_pkg::ST_FIRST;
                end
            end
            default: begin
                core_next.st = decoder_pkg::ST_FIRST;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            core_reg <= '0;
        end else begin
            core_reg <= core_next;
        end
    end

    assign fetch_ready       = (core_reg.st != decoder_pkg::ST_STALL);
    assign nop_slot          = (core_reg.st == decoder_pkg::ST_STALL); // see RULE5
    assign issue_valid       = core_reg.issue;
    assign cycle_count       = core_reg.dec.cycles;
    assign category          = core_reg.dec.category;
    assign opcode            = core_reg.dec.opcode;
    assign two_word          = core_reg.dec.two_word;
    assign base_source_reg   = core_reg.dec.base_source_reg;
    assign second_source_reg = core_reg.dec.second_source_reg;
    assign src_mode          = core_reg.dec.src_mode;
    assign dest_reg          = core_reg.dec.dest_reg;
    assign dest_mode         = core_reg.dec.dest_mode;
    assign dest_present      = core_reg.dec.dest_present;
    assign file_addr         = core_reg.dec.file_addr;
    assign to_file           = core_reg.dec.to_file;
    assign bit_sel           = core_reg.dec.bit_sel;
    assign bit_indirect      = core_reg.dec.bit_indirect;
    assign literal           = core_reg.dec.literal;
    assign acc_sel           = core_reg.dec.acc_sel;
    assign mult_pair         = core_reg.dec.mult_pair;
    assign x_prefetch        = core_reg.dec.x_prefetch;
    assign y_prefetch        = core_reg.dec.y_prefetch;
    assign x_dest            = core_reg.dec.x_dest;
    assign y_dest            = core_reg.dec.y_dest;
    assign awb_valid         = core_reg.dec.awb_valid;
    assign awb_indirect      = core_reg.dec.awb_indirect;
    assign dsp_is_dest       = core_reg.dec.dsp_is_dest;
    assign shift_by_reg      = core_reg.dec.shift_by_reg;
    assign shift_amount_reg  = core_reg.dec.shift_amount_reg;
    assign shift_literal     = core_reg.dec.shift_literal;
    assign prog_addr         = core_reg.dec.prog_addr;
    assign table_mode        = core_reg.dec.table_mode;

endmodule // instr_decoder

//--- tb/instr_decoder_chk.sv
`timescale 1ns/1ps
module instr_decoder_chk (
    input  wire logic                   clk_sys,
    input  wire logic                   sys_rst,
    input  wire logic                   fetch_valid,
    input  wire logic [23:0]            fetch_word,
    input  wire logic                   fetch_ready,
    input  wire logic                   issue_valid,
    input  wire logic                   nop_slot,
    input  wire logic [1:0]             cycle_count,
    input  wire decoder_pkg::category_t category,
    input  wire logic [7:0]             opcode,
    input  wire logic                   two_word
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    logic       take;
    logic [7:0] top;
    assign take = fetch_valid && fetch_ready;
    assign top  = fetch_word[23:16];

    reset_state_a: assert property ($fell(sys_rst) |-> fetch_ready && !issue_valid && !nop_slot)
        else $error("outputs not idle after reset");
    stall_two_a: assert property (
        issue_valid && cycle_count == 2'h2 |-> nop_slot && !fetch_ready ##1 fetch_ready && !nop_slot)
        else $error("two cycle instruction stalls wrongly");
    stall_three_a: assert property (
        issue_valid && cycle_count == 2'h3 |-> (nop_slot && !fetch_ready) [*2] ##1 fetch_ready)
        else $error("three cycle instruction stalls wrongly");
    single_ready_a: assert property (
        issue_valid && cycle_count == 2'h1 |-> fetch_ready && !nop_slot)
        else $error("single cycle instruction stalls");
    count_range_a: assert property (
        issue_valid |-> cycle_count != 2'h0 && category inside {[3'h0:3'h4]})
        else $error("cycle count or category out of range");
    two_cyc_a: assert property (
        issue_valid && two_word |-> cycle_count == 2'h2 && opcode inside {8'h02, 8'h04, 8'h08})
        else $error("two word issue wrong");
    nop_word_a: assert property (
        issue_valid && opcode == 8'h00 |-> category == decoder_pkg::CAT_CONTROL
        && cycle_count == 2'h1 && !two_word) else $error("zero opcode not a nop");
    branch_take_a: assert property (
        take && top == 8'h37 |=> issue_valid && cycle_count == 2'h2)
        else $error("branch cycle count wrong");
    ret_take_a: assert property (
        take && top inside {8'h06, 8'h07} |=> issue_valid && cycle_count == 2'h3)
        else $error("return cycle count wrong");
    pair_wait_a: assert property (
        take && top inside {8'h02, 8'h04, 8'h08} |=> !issue_valid && fetch_ready)
        else $error("two word issued before second word");

    cover property (issue_valid && two_word);
    cover property (issue_valid && cycle_count == 2'h3);
    cover property (issue_valid ##1 issue_valid);
endmodule // instr_decoder_chk

bind instr_decoder instr_decoder_chk u_instr_decoder_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .fetch_ready(fetch_ready), .issue_valid(issue_valid),
    .nop_slot(nop_slot), .cycle_count(cycle_count), .category(category),
    .opcode(opcode), .two_word(two_word));

//--- tb/fetch_path_model.sv
`timescale 1ns/1ps
module fetch_path_model (
    input  wire logic        clk_sys,
    input  wire logic        restart,
    input  wire logic        run,
    input  wire logic        fetch_ready,
    output logic             fetch_valid,
    output logic [23:0]      fetch_word,
    output logic [23:0]      next_word,
    output logic             cond_true
);
    // Entry holds the condition result above the program word
    logic [24:0] mem [0:15];
    logic [3:0]  pc_reg = 4'h0;
    always @(posedge clk_sys) begin
        if (restart) begin
            pc_reg <= 4'h0;
        end else if (fetch_valid && fetch_ready) begin
            pc_reg <= pc_reg + 4'h1;
        end
    end
    // Idle bus shows an inverted word so stale data cannot be mistaken
    assign fetch_valid = run;
    assign fetch_word  = run ? mem[pc_reg][23:0] : ~mem[pc_reg][23:0];
    assign next_word   = mem[pc_reg + 4'h1][23:0];
    assign cond_true   = run ? mem[pc_reg][24] : 1'b0;
endmodule // fetch_path_model

//--- tb/instr_decoder_tb.sv
`timescale 1ns/1ps
module instr_decoder_tb;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic restart = 1'b1;
    logic run     = 1'b0;
    logic fetch_valid, fetch_ready, cond_true, issue_valid, nop_slot, two_word;
    logic [23:0] fetch_word, next_word;
    logic [1:0]  cycle_count;
    logic [22:0] prog_addr;
    logic [7:0]  opcode;
    logic [3:0]  base_source_reg, second_source_reg, dest_reg;
    logic [1:0]  src_mode;
    logic [12:0] file_addr;
    logic [15:0] literal;
    logic        dest_present, to_file, acc_sel, awb_valid, awb_indirect;
    decoder_pkg::category_t category;
    int fail_count = 0;
    int comparisons = 0;

    always #25 clk_sys = ~clk_sys;

    fetch_path_model u_fetch_path_model (.clk_sys(clk_sys), .restart(restart), .run(run),
        .fetch_ready(fetch_ready), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
        .next_word(next_word), .cond_true(cond_true));

    instr_decoder u_instr_decoder (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .fetch_valid(fetch_valid), .fetch_word(fetch_word), .next_word(next_word),
        .cond_true(cond_true), .fetch_ready(fetch_ready), .issue_valid(issue_valid),
        .nop_slot(nop_slot), .cycle_count(cycle_count), .category(category), .opcode(opcode),
        .two_word(two_word), .base_source_reg(base_source_reg),
        .second_source_reg(second_source_reg), .src_mode(src_mode), .dest_reg(dest_reg),
        .dest_mode(), .dest_present(dest_present), .file_addr(file_addr), .to_file(to_file),
        .bit_sel(), .bit_indirect(), .literal(literal), .acc_sel(acc_sel), .mult_pair(),
        .x_prefetch(), .y_prefetch(), .x_dest(), .y_dest(), .awb_valid(awb_valid),
        .awb_indirect(awb_indirect), .dsp_is_dest(), .shift_by_reg(),
        .shift_amount_reg(), .shift_literal(), .prog_addr(prog_addr), .table_mode());

    task step;
        @(posedge clk_sys);
        #1;
    endtask

    task summarize;
        $display("compared %0d, mismatched %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Stop fetching, rewind and fill the program with nops
    task prep;
        run = 1'b0;
        restart = 1'b1;
        repeat (5) step();
        for (int i = 0; i < 16; i++) u_fetch_path_model.mem[i] = 25'h0;
        restart = 1'b0;
    endtask

    // Category 7 means not checked
    task automatic expect_instr(input logic [1:0] cyc, input logic [2:0] cat, input logic tw,
                                input logic pa_on, input logic [22:0] pa);
        int n;
        n = 0;
        while (issue_valid !== 1'b1 && n < 20) begin
            step();
            n++;
        end
        if (n == 20) begin
            chk(32'h0, 32'h1);
            summarize();
        end
        chk(cycle_count, cyc);
        if (cat != 3'h7) chk(category, cat);
        chk(two_word, tw);
        if (pa_on) chk(prog_addr, pa);
        n = 0;
        while (fetch_ready !== 1'b1 && n < 5) begin
            chk(nop_slot, 1'b1);
            step();
            n++;
        end
        chk(n, cyc - 2'h1);
        step();
    endtask

    task t_single;
        logic [23:0] w [7] = '{24'h401234, 24'hA01234, 24'h20ABCD, 24'hB01234,
                               24'hC01234, 24'hF01234, 24'h000000};
        logic [2:0]  c [7] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4};
        prep();
        for (int i = 0; i < 7; i++) u_fetch_path_model.mem[i] = {1'b0, w[i]};
        run = 1'b1;
        for (int i = 0; i < 7; i++) expect_instr(2'h1, c[i], 1'b0, 1'b0, 23'h0);
        run = 1'b0;
        $display("test single done");
    endtask

    task t_flow;
        logic [24:0] w [9] = '{25'h0370010, 25'h0010000, 25'h0060000, 25'h0070000,
                               25'h0BA0000, 25'h0BB0000, 25'h0BE0000, 25'h1300004,
                               25'h0300004};
        logic [1:0]  y [9] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1};
        logic [2:0]  c [9] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7};
        prep();
        for (int i = 0; i < 9; i++) u_fetch_path_model.mem[i] = w[i];
        run = 1'b1;
        for (int i = 0; i < 9; i++) expect_instr(y[i], c[i], 1'b0, 1'b0, 23'h0);
        run = 1'b0;
        $display("test flow done");
    endtask

    task t_two;
        logic [23:0] a, b;
        a = 24'h04ABCE;
        b = 24'h000055;
        prep();
        u_fetch_path_model.mem[0] = 25'h0020010;
        u_fetch_path_model.mem[1] = 25'h0000011;
        u_fetch_path_model.mem[2] = {1'b0, a};
        u_fetch_path_model.mem[3] = {1'b0, b};
        u_fetch_path_model.mem[4] = 25'h0080020;
        u_fetch_path_model.mem[5] = 25'h0000003;
        u_fetch_path_model.mem[6] = 25'h0000123;
        run = 1'b1;
        expect_instr(2'h2, 3'h4, 1'b1, 1'b0, 23'h0);
        expect_instr(2'h2, 3'h4, 1'b1, 1'b1, {b[6:0], a[15:1], 1'b0});
        expect_instr(2'h2, 3'h7, 1'b1, 1'b0, 23'h0);
        expect_instr(2'h1, 3'h4, 1'b0, 1'b0, 23'h0);
        run = 1'b0;
        $display("test two word done");
    endtask

    task t_skip;
        logic [24:0] w [8] = '{25'h1A40001, 25'h0401111, 25'h1A50002, 25'h0020000,
                               25'h0000010, 25'h0A60003, 25'h0402222, 25'h0000000};
        logic [1:0]  y [6] = '{2'h2, 2'h1, 2'h3, 2'h2, 2'h1, 2'h1};
        logic [2:0]  c [6] = '{3'h1, 3'h0, 3'h1, 3'h4, 3'h1, 3'h0};
        logic        t [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
        prep();
        for (int i = 0; i < 8; i++) u_fetch_path_model.mem[i] = w[i];
        run = 1'b1;
        for (int i = 0; i < 6; i++) expect_instr(y[i], c[i], t[i], 1'b0, 23'h0);
        run = 1'b0;
        $display("test skip done");
    endtask

    // Operand fields are checked while the issued instruction stands
    task automatic t_fields;
        logic [23:0] w [5] = '{24'h401234, 24'hB51234, 24'h2ABCD5, 24'hB37F22, 24'hC38000};
        logic [31:0] g, x;
        int n;
        prep();
        for (int i = 0; i < 5; i++) u_fetch_path_model.mem[i] = {1'b0, w[i]};
        run = 1'b1;
        for (int i = 0; i < 5; i++) begin
            n = 0;
            while (issue_valid !== 1'b1 && n < 20) begin
                step();
                n++;
            end
            g = 32'h0;
            x = 32'h1;
            case (i)
                0: begin
                    g = {opcode, base_source_reg, dest_reg, src_mode, second_source_reg,
                         dest_present};
                    x = {8'h40, 4'h1, 4'h8, 2'h3, 4'h4, 1'b1};
                end
                1: begin
                    g = {file_addr, to_file};
                    x = {13'h1234, 1'b0};
                end
                2: begin
                    g = {literal, base_source_reg};
                    x = {16'hABCD, 4'h5};
                end
                3: begin
                    g = {literal, file_addr, to_file};
                    x = {16'h0022, 13'h007F, 1'b1};
                end
                default: begin
                    g = {acc_sel, awb_valid, awb_indirect};
                    x = 32'h7;
                end
            endcase
            chk(g, x);
            expect_instr(2'h1, 3'h7, 1'b0, 1'b0, 23'h0);
        end
        run = 1'b0;
        $display("test fields done");
    endtask

    task t_reset;
        int n;
        prep();
        u_fetch_path_model.mem[0] = 25'h0060000;
        run = 1'b1;
        n = 0;
        while (issue_valid !== 1'b1 && n < 20) begin
            step();
            n++;
        end
        if (n == 20) begin
            chk(32'h0, 32'h1);
            summarize();
        end
        sys_rst = 1'b1;
        run = 1'b0;
        step();
        sys_rst = 1'b0;
        chk({fetch_ready, issue_valid, nop_slot}, 32'h4);
        step();
        chk({fetch_ready, issue_valid, nop_slot}, 32'h4);
        $display("test reset done");
    endtask

    initial begin
        repeat (3) step();
        sys_rst = 1'b0;
        t_single();
        t_flow();
        t_two();
        t_skip();
        t_fields();
        t_reset();
        summarize();
    end
endmodule // instr_decoder_tb
